// >>> logic/io_index_pkg.sv
/*
 * constants, types and field layouts shared by the channel buffer index
 * control block and its helpers.
 * assumes one 100 MHz clock domain and synchronous active-high reset.
 */
package io_index_pkg;

    localparam int NUM_CH = 4;
    localparam int CH_W   = 2;
    localparam int ESI_N  = 16;
    localparam int ESI_W  = 4;

    // buffer control word layout
    localparam int WORD_W       = 30;
    localparam int ADDR_LSB     = 0;
    localparam int ADDR_W       = 17;
    localparam int UNUSED_BIT   = 17;
    localparam int COUNT_LSB    = 18;
    localparam int COUNT_W      = 12;
    localparam int ESI_IN_LSB   = 15;
    localparam int ESI_OUT_LSB  = 0;
    localparam int ESI_FIELD_W  = 15;
    localparam int MSR_W        = 2;
    localparam int PAR_W        = 2;

    // reset values
    localparam logic [WORD_W-1:0] WORD_RST   = 30'h0000_0000;
    localparam logic [PAR_W-1:0]  PAR_RST    = 2'h0;
    localparam logic [MSR_W-1:0]  MSR_RST    = 2'h0;
    localparam logic [NUM_CH-1:0] CH_FLAGS_RST = 4'h0;

    // status trap vector: value arbitrary
    localparam logic [ADDR_W-1:0] STATUS_TRAP_ADDR = 17'h00040;

    // time of day: one hundredth of a minute per tick
    localparam longint CLK_PERIOD_PS = 10000;
    localparam longint TOD_TICK_MS   = 600;
    localparam int TOD_TICK_CYCLES =
        int'((TOD_TICK_MS * 64'd1000000000) / CLK_PERIOD_PS);
    localparam logic [4:0] TOD_HOURS_MAX = 5'h17;
    localparam logic [5:0] TOD_MIN_MAX   = 6'h3b;
    localparam logic [6:0] TOD_HUND_MAX  = 7'h63;

    typedef enum logic [1:0] {
        TGT_INT  = 2'h0,
        TGT_EXT  = 2'h1,
        TGT_MSR  = 2'h2,
        TGT_MODE = 2'h3
    } target_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_READ  = 2'h1,
        ST_WRITE = 2'h3
    } xfer_state_e;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               unused;
        logic [ADDR_W-1:0]  addr;
    } buffer_control_word_s;

    typedef struct packed {
        target_e            target;
        logic [CH_W-1:0]    channel;
        logic [ESI_W-1:0]   index;
        logic [WORD_W-1:0]  word;
        logic [PAR_W-1:0]   parity;
        logic               monitor;
    } load_s;

    typedef struct packed {
        target_e            target;
        logic [CH_W-1:0]    channel;
        logic [ESI_W-1:0]   index;
    } read_sel_s;

    typedef struct packed {
        logic [CH_W-1:0]    channel;
        logic               input_dir;
        logic [WORD_W-1:0]  data;
    } request_s;

    typedef struct packed {
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [6:0] hundredths;
    } tod_s;

endpackage : io_index_pkg

// >>> logic/buffer_word_update.sv
/*
 * combinational update of one buffer control word for one transfer.
 * assumes the caller holds the word stable and supplies the mode,
 * direction and memory select bits.
 */
`timescale 1ns/10ps
module buffer_word_update
    import io_index_pkg::*;
(
    input  wire logic [WORD_W-1:0] word,
    input  wire logic              ext_mode,
    input  wire logic              input_dir,
    input  wire logic [MSR_W-1:0]  memory_select_register,
    output logic      [WORD_W-1:0] next_word,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic                   count_zero
);
    import io_index_pkg::*;

    buffer_control_word_s     cur;
    buffer_control_word_s     isi_next;
    logic [ESI_FIELD_W-1:0]   in_field;
    logic [ESI_FIELD_W-1:0]   out_field;
    logic [WORD_W-1:0]        esi_next;

    assign cur = buffer_control_word_s'(word);
    assign in_field  = word[ESI_IN_LSB +: ESI_FIELD_W];
    assign out_field = word[ESI_OUT_LSB +: ESI_FIELD_W];

    assign isi_next.addr   = cur.addr + 17'h00001;
    assign isi_next.unused = cur.unused;
    assign isi_next.count  = cur.count - 12'h001;

    assign esi_next = input_dir
        ? {in_field + 15'h0001, out_field}
        : {in_field, out_field + 15'h0001};

    assign next_word = ext_mode ? esi_next : WORD_W'(isi_next);
    assign mem_addr = ext_mode
        ? {memory_select_register, (input_dir ? in_field : out_field)}
        : cur.addr;
    assign count_zero = (isi_next.count == 12'h000);

endmodule : buffer_word_update

// >>> logic/tod_counter.sv
/*
 * time of day counter in hours, minutes and hundredths of minutes.
 * assumes panel controls are already synchronised levels.
 */
`timescale 1ns/10ps
module tod_counter
    import io_index_pkg::*;
#(
    parameter int TICK_CYCLES = TOD_TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clear,
    input  wire logic stop,
    input  wire logic start,
    input  wire logic set,
    input  wire tod_s set_value,
    output tod_s      value
);
    import io_index_pkg::*;

    tod_s        tod_reg;
    tod_s        tod_next;
    logic        run_reg;
    logic [25:0] div_reg;
    logic        tick;
    logic        hund_wrap;
    logic        min_wrap;

    assign tick = run_reg && (div_reg == 26'(TICK_CYCLES - 1));
    assign hund_wrap = (tod_reg.hundredths == TOD_HUND_MAX);
    assign min_wrap  = (tod_reg.minutes == TOD_MIN_MAX);

    always_comb
    begin
        tod_next = tod_reg;
        if (tick)
        begin
            tod_next.hundredths = hund_wrap ? 7'h00 : tod_reg.hundredths + 7'h01;
            if (hund_wrap)
            begin
                tod_next.minutes = min_wrap ? 6'h00 : tod_reg.minutes + 6'h01;
                if (min_wrap)
                    tod_next.hours = (tod_reg.hours == TOD_HOURS_MAX)
                        ? 5'h00 : tod_reg.hours + 5'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset || clear)
        begin
            tod_reg <= '0;
            div_reg <= '0;
            run_reg <= reset ? 1'b0 : run_reg;
        end
        else if (set)
        begin
            tod_reg <= set_value;
            div_reg <= '0;
        end
        else
        begin
            tod_reg <= tod_next;
            div_reg <= (tick || !run_reg) ? 26'h0 : div_reg + 26'h1;
            run_reg <= stop ? 1'b0 : (start ? 1'b1 : run_reg);
        end
    end

    assign value = tod_reg;

endmodule : tod_counter

// >>> logic/io_channel_buffer_index_control.sv
/*
 * buffer index control for word-wide i/o channels: per-channel internal
 * index registers, a shared external index table, function/status
 * signalling and the channel 0 console day clock.
 * assumes requests and loads come from logic on clk; interrupt lines and
 * panel controls are pins and are synchronised here.
 */
//
// Contract
// - address field increments after each word
// - count field decrements after each word
// - count zero after transfer ends buffer
// - internal mode: one register per channel
// - internal register loaded before transfers start
// - external mode: many registers chosen by index
// - external input address from bits 15-29
// - external output address from bits 0-14
// - memory select adds two high address bits
// - function word raises external function line
// - interrupt line forces status trap address
// - console and day clock on channel 0
// - day clock in hours, minutes, hundredths
// - day clock clear, stop, start, set
// - parity error zeroes word, ends internal only
// - monitored buffer full/empty raises monitor interrupt
`timescale 1ns/10ps
module io_channel_buffer_index_control
    import io_index_pkg::*;
#(
    parameter int TOD_TICKS = TOD_TICK_CYCLES
)
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    load_valid,
    input  wire io_index_pkg::load_s     load,
    input  wire io_index_pkg::read_sel_s rd_sel,
    output logic [io_index_pkg::WORD_W-1:0] rd_data,
    input  wire logic                    req_valid,
    input  wire io_index_pkg::request_s  req,
    output logic                         req_ready,
    output logic                         mem_valid,
    output logic [io_index_pkg::ADDR_W-1:0] mem_addr,
    output logic                         mem_write,
    output logic                         xfer_refused,
    output logic                         buffer_end,
    output logic                         monitor_irq,
    output logic                         parity_irq,
    input  wire logic                    func_valid,
    input  wire logic [io_index_pkg::WORD_W-1:0] func_word,
    output logic [io_index_pkg::WORD_W-1:0] out_data,
    output logic                         ext_function,
    input  wire logic [io_index_pkg::NUM_CH-1:0] external_interrupt_line,
    output logic                         trap_valid,
    output logic [io_index_pkg::CH_W-1:0] trap_channel,
    output logic [io_index_pkg::ADDR_W-1:0] trap_addr,
    input  wire logic                    panel_clear,
    input  wire logic                    panel_stop,
    input  wire logic                    panel_start,
    input  wire logic                    panel_set,
    input  wire io_index_pkg::tod_s      panel_set_value,
    output io_index_pkg::tod_s           tod_value
);
    import io_index_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // index storage

    logic [WORD_W-1:0] int_word_reg [NUM_CH];
    logic [PAR_W-1:0]  int_par_reg  [NUM_CH];
    logic [NUM_CH-1:0] int_mon_reg;
    logic [NUM_CH-1:0] active_reg;
    logic [NUM_CH-1:0] ext_mode_reg;
    logic [WORD_W-1:0] ext_word_reg [ESI_N];
    logic [PAR_W-1:0]  ext_par_reg  [ESI_N];
    logic [MSR_W-1:0]  msr_reg;

    xfer_state_e       state_reg;
    request_s          cur_reg;
    logic              cur_ext_reg;
    logic [ESI_W-1:0]  cur_idx_reg;
    logic [WORD_W-1:0] rd_word_reg;
    logic [PAR_W-1:0]  rd_par_reg;

    logic              load_int;
    logic              load_ext;
    logic              sel_ext;
    logic [ESI_W-1:0]  sel_idx;
    logic              perr;
    logic              cur_dir;
    logic              isi_live;
    logic              wb_fire;
    logic              wb_isi;
    logic              wb_esi;
    logic              wb_write;
    logic [WORD_W-1:0] wb_word;
    logic [PAR_W-1:0]  wb_par;
    logic [WORD_W-1:0] upd_word;
    logic [ADDR_W-1:0] upd_addr;
    logic              upd_zero;

    assign load_int = load_valid && (load.target == TGT_INT);
    assign load_ext = load_valid && (load.target == TGT_EXT);

    // index on the input lines names device and direction
    assign sel_ext = ext_mode_reg[req.channel];
    assign sel_idx = req.data[ESI_W-1:0];
    assign cur_dir = cur_ext_reg ? cur_idx_reg[0] : cur_reg.input_dir;

    assign perr = (rd_par_reg != {^rd_word_reg[29:15], ^rd_word_reg[14:0]});
    assign isi_live = active_reg[cur_reg.channel];
    assign wb_fire  = (state_reg == ST_WRITE);
    assign wb_isi   = wb_fire && !cur_ext_reg && isi_live && !perr;
    assign wb_esi   = wb_fire && cur_ext_reg && !perr;
    assign wb_write = wb_fire && (cur_ext_reg || isi_live);
    assign wb_word  = perr ? WORD_RST : upd_word;
    assign wb_par   = {^wb_word[29:15], ^wb_word[14:0]};

    buffer_word_update u_update (
        .word       (rd_word_reg),
        .ext_mode   (cur_ext_reg),
        .input_dir  (cur_dir),
        .memory_select_register        (msr_reg),
        .next_word  (upd_word),
        .mem_addr   (upd_addr),
        .count_zero (upd_zero)
    );

    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_int
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    int_word_reg[c] <= WORD_RST;
                    int_par_reg[c]  <= PAR_RST;
                end
                else if (load_int && load.channel == CH_W'(c))
                begin
                    int_word_reg[c] <= load.word;
                    int_par_reg[c]  <= load.parity;
                end
                else if (wb_write && !cur_ext_reg &&
                         cur_reg.channel == CH_W'(c))
                begin
                    int_word_reg[c] <= wb_word;
                    int_par_reg[c]  <= wb_par;
                end
            end
        end
        for (genvar e = 0; e < ESI_N; e++)
        begin : g_ext
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    ext_word_reg[e] <= WORD_RST;
                    ext_par_reg[e]  <= PAR_RST;
                end
                else if (load_ext && load.index == ESI_W'(e))
                begin
                    ext_word_reg[e] <= load.word;
                    ext_par_reg[e]  <= load.parity;
                end
                else if (wb_write && cur_ext_reg && cur_idx_reg == ESI_W'(e))
                begin
                    ext_word_reg[e] <= wb_word;
                    ext_par_reg[e]  <= wb_par;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // channel flags and memory select

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            active_reg   <= CH_FLAGS_RST;
            int_mon_reg  <= CH_FLAGS_RST;
            ext_mode_reg <= CH_FLAGS_RST;
            msr_reg      <= MSR_RST;
        end
        else
        begin
            if (load_int)
            begin
                active_reg[load.channel]  <= 1'b1;
                int_mon_reg[load.channel] <= load.monitor;
            end
            else if (wb_fire && !cur_ext_reg && (perr || upd_zero))
                active_reg[cur_reg.channel] <= 1'b0;
            if (load_valid && load.target == TGT_MODE)
                ext_mode_reg <= load.word[NUM_CH-1:0];
            if (load_valid && load.target == TGT_MSR)
                msr_reg <= load.word[MSR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer: read, then write back, one request at a time

    assign req_ready = (state_reg == ST_IDLE);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg   <= ST_IDLE;
            cur_reg     <= '0;
            cur_ext_reg <= 1'b0;
            cur_idx_reg <= '0;
            rd_word_reg <= WORD_RST;
            rd_par_reg  <= PAR_RST;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (req_valid)
                    begin
                        cur_reg     <= req;
                        cur_ext_reg <= sel_ext;
                        cur_idx_reg <= sel_idx;
                        state_reg   <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    rd_word_reg <= cur_ext_reg ? ext_word_reg[cur_idx_reg]
                                               : int_word_reg[cur_reg.channel];
                    rd_par_reg  <= cur_ext_reg ? ext_par_reg[cur_idx_reg]
                                               : int_par_reg[cur_reg.channel];
                    state_reg   <= ST_WRITE;
                end
                ST_WRITE:
                    state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mem_valid    <= 1'b0;
            mem_addr     <= '0;
            mem_write    <= 1'b0;
            xfer_refused <= 1'b0;
            buffer_end   <= 1'b0;
            monitor_irq  <= 1'b0;
            parity_irq   <= 1'b0;
        end
        else
        begin
            mem_valid    <= wb_isi || wb_esi;
            mem_addr     <= upd_addr;
            mem_write    <= cur_dir;
            xfer_refused <= wb_fire && !cur_ext_reg && !isi_live;
            buffer_end   <= wb_isi && upd_zero;
            monitor_irq  <= wb_isi && upd_zero &&
                            int_mon_reg[cur_reg.channel];
            parity_irq   <= wb_write && perr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register readback

    always_ff @(posedge clk)
    begin
        if (reset)
            rd_data <= WORD_RST;
        else
            unique case (rd_sel.target)
                TGT_INT:  rd_data <= int_word_reg[rd_sel.channel];
                TGT_EXT:  rd_data <= ext_word_reg[rd_sel.index];
                TGT_MSR:  rd_data <= WORD_W'(msr_reg);
                TGT_MODE: rd_data <= WORD_W'({active_reg, ext_mode_reg});
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // function words out, status traps in

    logic [NUM_CH-1:0] ei_s1_reg;
    logic [NUM_CH-1:0] ei_s2_reg;
    logic [NUM_CH-1:0] ei_d_reg;
    logic [NUM_CH-1:0] ei_rise;
    logic [CH_W-1:0]   ei_first;
    logic [3:0]        pnl_s1_reg;
    logic [3:0]        pnl_s2_reg;

    assign ei_rise = ei_s2_reg & ~ei_d_reg;

    always_comb
    begin
        ei_first = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (ei_rise[i])
                ei_first = CH_W'(i);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ei_s1_reg    <= '0;
            ei_s2_reg    <= '0;
            ei_d_reg     <= '0;
            pnl_s1_reg   <= '0;
            pnl_s2_reg   <= '0;
            out_data     <= WORD_RST;
            ext_function <= 1'b0;
            trap_valid   <= 1'b0;
            trap_channel <= '0;
            trap_addr    <= '0;
        end
        else
        begin
            ei_s1_reg    <= external_interrupt_line;
            ei_s2_reg    <= ei_s1_reg;
            ei_d_reg     <= ei_s2_reg;
            pnl_s1_reg   <= {panel_clear, panel_stop, panel_start, panel_set};
            pnl_s2_reg   <= pnl_s1_reg;
            ext_function <= func_valid;
            if (func_valid)
                out_data <= func_word;
            trap_valid   <= |ei_rise;
            if (|ei_rise)
            begin
                trap_channel <= ei_first;
                trap_addr    <= STATUS_TRAP_ADDR;
            end
        end
    end

    // console day clock, served on channel 0
    tod_counter #(
        .TICK_CYCLES (TOD_TICKS)
    ) u_tod (
        .clk       (clk),
        .reset     (reset),
        .clear     (pnl_s2_reg[3]),
        .stop      (pnl_s2_reg[2]),
        .start     (pnl_s2_reg[1]),
        .set       (pnl_s2_reg[0]),
        .set_value (panel_set_value),
        .value     (tod_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_addr_increment: assert property (@(posedge clk) disable iff (reset)
        wb_isi |=> int_word_reg[$past(cur_reg.channel)][16:0] ==
                   $past(rd_word_reg[16:0]) + 17'h00001)
        else $error("address field did not increment");

    a_count_decrement: assert property (@(posedge clk) disable iff (reset)
        wb_isi |=> int_word_reg[$past(cur_reg.channel)][29:18] ==
                   $past(rd_word_reg[29:18]) - 12'h001)
        else $error("count field did not decrement");

    a_end_on_zero: assert property (@(posedge clk) disable iff (reset)
        (wb_isi && rd_word_reg[29:18] == 12'h001) |=>
            buffer_end && !active_reg[$past(cur_reg.channel)])
        else $error("buffer not ended at zero count");

    a_parity_zero: assert property (@(posedge clk) disable iff (reset)
        (wb_write && perr && !cur_ext_reg) |=>
            int_word_reg[$past(cur_reg.channel)] == WORD_RST && parity_irq)
        else $error("parity error did not zero the word");

    a_esi_input_addr: assert property (@(posedge clk) disable iff (reset)
        (wb_esi && cur_dir) |=>
            mem_addr[14:0] == $past(rd_word_reg[29:15]) && mem_write)
        else $error("external input address wrong");

    a_esi_high_bits: assert property (@(posedge clk) disable iff (reset)
        wb_esi |=> mem_valid && mem_addr[16:15] == $past(msr_reg))
        else $error("memory select bits missing");

    a_function_line: assert property (@(posedge clk) disable iff (reset)
        func_valid |=> ext_function && out_data == $past(func_word))
        else $error("function line not raised with word");

    a_status_trap: assert property (@(posedge clk) disable iff (reset)
        $rose(external_interrupt_line[0]) ##1 external_interrupt_line[0]
            |-> ##[1:2] (trap_valid && trap_channel == '0 &&
                         trap_addr == STATUS_TRAP_ADDR))
        else $error("status trap not taken");

    a_rmw_sequence: assert property (@(posedge clk) disable iff (reset)
        (req_ready && req_valid) |=> !req_ready [*2] ##1 req_ready)
        else $error("read-modify-write not single");

    a_monitor_irq: assert property (@(posedge clk) disable iff (reset)
        monitor_irq |-> buffer_end && $past(int_mon_reg[cur_reg.channel]))
        else $error("monitor interrupt without monitored end");

endmodule : io_channel_buffer_index_control

// >>> sim/status_peripheral.sv
/* far-side peripheral: answers a function word with an interrupt.
   assumes ext_function pulses one cycle on clk. */
`timescale 1ns/10ps
module status_peripheral
(
    input  wire logic clk,
    input  wire logic ext_function,
    output logic      status_irq
);
    initial
    begin
        status_irq = 1'h0;
        forever
        begin
            @(posedge ext_function);
            repeat (2) @(negedge clk);
            status_irq = 1'h1;
            repeat (4) @(negedge clk);
            status_irq = 1'h0;
        end
    end
endmodule : status_peripheral

// >>> sim/io_channel_buffer_index_control_tb.sv
/* bench for the buffer index control block.
   assumes status_peripheral sits on interrupt line 3 and the console
   interrupt key on line 0. */
`timescale 1ns/10ps
module io_channel_buffer_index_control_tb;
    import io_index_pkg::*;
    logic clk = 0, reset = 1, load_valid = 0, req_valid = 0;
    logic func_valid = 0, req_ready, mem_valid, mem_write;
    logic xfer_refused, buffer_end, monitor_irq, parity_irq;
    logic ext_function, trap_valid, status_irq;
    logic [WORD_W-1:0] rd_data, out_data, func_word = '0;
    logic [ADDR_W-1:0] mem_addr, trap_addr;
    logic [CH_W-1:0]   trap_channel;
    load_s load = '0;
    read_sel_s rd_sel = '0;
    request_s req = '0;
    tod_s tod_value;
    tod_s panel_set_value = '0;
    logic [3:0] panel = '0;
    logic console_key = 0;
    int failures = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    io_channel_buffer_index_control #(.TOD_TICKS(4))
        io_channel_buffer_index_control_inst
    (
        .clk, .reset, .load_valid, .load, .rd_sel, .rd_data, .req_valid,
        .req, .req_ready, .mem_valid, .mem_addr, .mem_write, .xfer_refused,
        .buffer_end, .monitor_irq, .parity_irq, .func_valid, .func_word,
        .out_data, .ext_function, .external_interrupt_line({status_irq,
        2'h0, console_key}), .trap_valid, .trap_channel, .trap_addr,
        .panel_clear(panel[3]), .panel_stop(panel[2]),
        .panel_start(panel[1]), .panel_set(panel[0]),
        .panel_set_value, .tod_value
    );
    status_peripheral status_peripheral_inst (.clk, .ext_function,
        .status_irq);
    ////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [WORD_W-1:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic put(target_e t, logic [3:0] c, logic [29:0] w,
                       logic [1:0] b);
        @(negedge clk);
        load_valid = 1;
        load = '{t, c[1:0], c, w, {^w[29:15], ^w[14:0] ^ b[0]}, b[1]};
        @(negedge clk);
        load_valid = 0;
    endtask : put
    task automatic peek(target_e t, logic [3:0] c, logic [29:0] e);
        rd_sel = '{t, c[1:0], c};
        repeat (2) @(negedge clk);
        check("rd_data", rd_data, e);
    endtask : peek
    task automatic xfer(logic [1:0] c, bit d, logic [3:0] i, f,
                        logic [17:0] a);
        @(negedge clk);
        check("req_ready", req_ready, 1);
        req_valid = 1;
        req = '{c, d, {26'h0, i}};
        @(negedge clk);
        req_valid = 0;
        repeat (2) @(negedge clk);
        check("flags", {mem_valid, buffer_end, xfer_refused, parity_irq}, f);
        if (f[3])
            check("addr", {mem_write, mem_addr}, a);
    endtask : xfer
    task automatic pulse(logic [3:0] p);
        @(negedge clk);
        panel = p;
        @(negedge clk);
        panel = '0;
    endtask : pulse
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            complete_run;
        end
    end
    initial
    begin
        repeat (6) @(negedge clk);
        reset = 0;
        put(TGT_INT, 1, 30'h0008_0100, 2);
        xfer(1, 1, 0, 4'h8, 18'h20100);
        xfer(1, 0, 0, 4'hc, 18'h00101);
        check("monitor_irq", monitor_irq, 1);
        peek(TGT_INT, 1, 30'h0000_0102);
        xfer(1, 1, 0, 4'h2, 0);
        $display("internal test done");
        put(TGT_MSR, 0, 30'h2, 0);
        put(TGT_MODE, 0, 30'h4, 0);
        put(TGT_EXT, 3, 30'h0008_0000, 0);
        put(TGT_EXT, 2, 30'h20, 0);
        xfer(2, 1, 3, 4'h8, 18'h30010);
        xfer(2, 0, 2, 4'h8, 18'h10020);
        peek(TGT_EXT, 3, 30'h0008_8000);
        $display("external test done");
        put(TGT_INT, 0, 30'h0008_0100, 1);
        xfer(0, 0, 0, 4'h1, 0);
        peek(TGT_INT, 0, 0);
        xfer(0, 0, 0, 4'h2, 0);
        put(TGT_EXT, 2, 30'h20, 1);
        xfer(2, 0, 2, 4'h1, 0);
        xfer(2, 0, 2, 4'h8, 18'h10000);
        $display("parity test done");
        @(negedge clk);
        func_valid = 1;
        func_word = 30'h1234;
        @(negedge clk);
        func_valid = 0;
        check("ext_function", ext_function, 1);
        check("out_data", out_data, 30'h1234);
        for (int i = 0; i < 20 && trap_valid !== 1'h1; i++)
            @(negedge clk);
        check("trap", {trap_valid, trap_channel, trap_addr},
              {3'h7, STATUS_TRAP_ADDR});
        @(negedge clk);
        console_key = 1;
        for (int i = 0; i < 20 && trap_valid !== 1'h1; i++)
            @(negedge clk);
        check("key_trap", {trap_valid, trap_channel, trap_addr},
              {3'h4, STATUS_TRAP_ADDR});
        console_key = 0;
        $display("function test done");
        panel_set_value = '{5'h1, 6'h2, 7'h3};
        pulse(4'h1);
        repeat (3) @(negedge clk);
        check("tod_set", tod_value, {5'h1, 6'h2, 7'h3});
        pulse(4'h2);
        repeat (8) @(negedge clk);
        check("tod_run", tod_value, {5'h1, 6'h2, 7'h4});
        pulse(4'h4);
        repeat (8) @(negedge clk);
        check("tod_stop", tod_value, {5'h1, 6'h2, 7'h5});
        pulse(4'h8);
        repeat (3) @(negedge clk);
        check("tod_clear", tod_value, 0);
        $display("day clock test done");
        complete_run;
    end
endmodule : io_channel_buffer_index_control_tb
